// File: accel_regs_pkg.sv
// constants, types and register map of the mode / interrupt-cause register group
package accel_regs_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_STATUS     = 8'h00;
	localparam logic [7:0] ADDR_X_MSB      = 8'h01;
	localparam logic [7:0] ADDR_Y_MSB      = 8'h03;
	localparam logic [7:0] ADDR_Z_MSB      = 8'h05;
	localparam logic [7:0] ADDR_OP_STATE   = 8'h0b;
	localparam logic [7:0] ADDR_CAUSE      = 8'h0c;
	localparam logic [7:0] ADDR_IDENT      = 8'h0d;
	localparam logic [7:0] ADDR_RANGE      = 8'h0e;
	localparam logic [7:0] ADDR_HPF        = 8'h0f;
	localparam logic [7:0] ADDR_ORIENT     = 8'h10;
	localparam logic [7:0] ADDR_FFMT_SRC   = 8'h20;
	localparam logic [7:0] ADDR_TRANSIENT_SOURCE_REGISTER  = 8'h21;
	localparam logic [7:0] ADDR_PULSE_SOURCE_REGISTER  = 8'h22;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int CAUSE_SLEEP_BIT  = 7;
	localparam int CAUSE_TRANS_BIT  = 5;
	localparam int CAUSE_ORIENT_BIT = 4;
	localparam int CAUSE_PULSE_BIT  = 3;
	localparam int CAUSE_FFMT_BIT   = 2;
	localparam int CAUSE_DRDY_BIT   = 0;
	localparam logic [7:0] RANGE_MASK   = 8'h03;
	localparam logic [7:0] HPF_MASK     = 8'h33;
	localparam logic [7:0] RANGE_RESET  = 8'h00;
	localparam logic [7:0] HPF_RESET    = 8'h00;
	localparam logic [1:0] FS_RESERVED  = 2'h3;
	localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;
	// arbitrary identity value
	localparam logic [7:0] IDENT_DEF    = 8'h5c;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ            = 40000000;
	localparam int SLEEP_TICK_MS     = 10;
	localparam int SLEEP_TICK_CYCLES = CLK_HZ / 1000 * SLEEP_TICK_MS;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_STANDBY = 2'b00,
		MODE_WAKE    = 2'b01,
		MODE_SLEEP   = 2'b10
	} op_mode_t;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_ADDR      = 4'b0001,
		ST_ADDR_ACK  = 4'b0010,
		ST_PTR       = 4'b0011,
		ST_PTR_ACK   = 4'b0100,
		ST_WDATA     = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA     = 4'b0111,
		ST_RDATA_ACK = 4'b1000
	} link_state_t;

	typedef struct packed {
		logic       trans_active;
		logic       trans_en;
		logic       pulse_active;
		logic       pulse_en;
		logic       ffmt_active;
		logic       ffmt_en;
		logic       orient_change;
		logic       orient_en;
		logic       drdy_en;
		logic       wake_event;
		logic       any_irq;
		logic [2:0] new_sample;
		logic [2:0] axis_en;
	} detect_in_t;

endpackage

// File: accel_mode_irq_status_regs.sv
// mode / interrupt-cause register group with its serial register port
//
// Contract
// - operating state 00 standby, 01 wake, 10 sleep
// - cause flags set on rise, held until read
// - cause bits 7,5,4,3,2,0; bits 6,1 zero
// - data-ready cause from ready/overwrite when enabled
// - data-ready cleared by xyz reads, not status read
// - sleep cause set on transition, cleared by state read
// - wake to sleep after countdown without interrupts
// - sleep to wake on wake-capable event, high rate
// - transient cause set on event rise, held until source read
// - orientation cause from change flag, cleared by read
// - pulse cause from event flag, cleared by read
// - freefall cause from event flag, cleared by read
// - fixed read-only identity register
// - full-scale 00 2g, 01 4g, 10 8g
// - reset gives 2g and filter off
// - cutoff from select code and sample rate
// - set-ready on new sample, cleared after msb reads
// - set-overwrite on unread overwrite, cleared likewise
// - orientation change flag cleared by orientation read
`timescale 1ns/1ps

module accel_mode_irq_status_regs
	import accel_regs_pkg::*;
#(
	parameter int         TICK_CYCLES = SLEEP_TICK_CYCLES,
	parameter logic [6:0] DEV_ADDR    = DEV_ADDR_DEF,
	parameter logic [7:0] IDENT       = IDENT_DEF
)(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire detect_in_t det,
	input  wire logic       active_in,
	input  wire logic       auto_sleep_en,
	input  wire logic [7:0] sleep_countdown_limit,
	input  wire logic [2:0] high_rate,
	input  wire logic [2:0] low_rate,
	input  wire logic [7:0] ext_rd_data,
	output logic [7:0]      reg_addr,
	output logic            rd_strobe,
	output logic            wr_strobe,
	output logic [7:0]      wr_data,
	output logic [1:0]      operating_state_field,
	output logic [2:0]      output_sample_rate,
	output logic [1:0]      full_scale_select,
	output logic [7:0]      highpass_cutoff_config,
	output logic [2:0]      hp_cutoff_shift,
	output logic            set_ready_flag,
	output logic            set_overwrite_flag,
	output logic            orientation_change_flag
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] scl_m_r, scl_s_r;
	logic scl_d_r, sda_d_r;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			scl_m_r <= 2'h3;
			scl_s_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_m_r <= {scl_in, sda_in};
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r[1];
			sda_d_r <= scl_s_r[0];
		end
	end

	logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_s     = scl_s_r[1];
	assign sda_s     = scl_s_r[0];
	assign scl_rise  = scl_s & ~scl_d_r;
	assign scl_fall  = ~scl_s & scl_d_r;
	assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// ****************************************
	// serial register port
	// ****************************************
	link_state_t st_r, st_nxt;
	logic [7:0]  shift_r, shift_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt, rd_mux;
	logic [2:0]  bit_r, bit_nxt;
	logic        done_r, done_nxt, oe_r, oe_nxt, rw_r, rw_nxt, nack_r, nack_nxt;
	logic        rd_nxt, rd_r, wr_nxt, wr_r;
	logic [7:0]  wdat_r;
	logic [7:0]  cause_r, cause_nxt, range_r, range_nxt, hpf_r, hpf_nxt;
	op_mode_t    mode_r, mode_nxt;

	always_comb
	begin
		case (ptr_r)
			ADDR_OP_STATE: rd_mux = {6'h00, mode_r};
			ADDR_CAUSE:    rd_mux = cause_r;
			ADDR_IDENT:    rd_mux = IDENT;
			ADDR_RANGE:    rd_mux = range_r;
			ADDR_HPF:      rd_mux = hpf_r;
			default:       rd_mux = ext_rd_data;
		endcase
	end

	always_comb
	begin
		st_nxt    = st_r;
		shift_nxt = shift_r;
		tx_nxt    = tx_r;
		ptr_nxt   = ptr_r;
		bit_nxt   = bit_r;
		done_nxt  = done_r;
		oe_nxt    = oe_r;
		rw_nxt    = rw_r;
		nack_nxt  = nack_r;
		rd_nxt    = 1'b0;
		wr_nxt    = 1'b0;
		if (bus_start)
		begin
			st_nxt   = ST_ADDR;
			bit_nxt  = 3'h0;
			done_nxt = 1'b0;
			oe_nxt   = 1'b0;
		end
		else if (bus_stop)
		begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end
		else if (scl_rise)
		begin
			shift_nxt = {shift_r[6:0], sda_s};
			bit_nxt   = bit_r + 3'h1;
			done_nxt  = (bit_r == 3'h7);
			nack_nxt  = sda_s;
		end
		else if (scl_fall)
		begin
			case (st_r)
				ST_ADDR:
				begin
					if (done_r && shift_r[7:1] == DEV_ADDR)
					begin
						st_nxt = ST_ADDR_ACK;
						rw_nxt = shift_r[0];
						oe_nxt = 1'b1;
					end
					else if (done_r)
						st_nxt = ST_IDLE;
				end
				ST_PTR, ST_WDATA:
				begin
					if (done_r)
					begin
						oe_nxt = 1'b1;
						st_nxt = (st_r == ST_PTR) ? ST_PTR_ACK : ST_WDATA_ACK;
						if (st_r == ST_PTR)
							ptr_nxt = shift_r;
						else
							wr_nxt = 1'b1;
					end
				end
				ST_PTR_ACK, ST_WDATA_ACK:
				begin
					oe_nxt   = 1'b0;
					st_nxt   = ST_WDATA;
					done_nxt = 1'b0;
					// ack clock also bumped the counter; realign for the next byte
					bit_nxt  = 3'h0;
					if (st_r == ST_WDATA_ACK)
						ptr_nxt = ptr_r + 8'h01;
				end
				ST_RDATA:
				begin
					if (done_r)
					begin
						oe_nxt = 1'b0;
						st_nxt = ST_RDATA_ACK;
					end
					else
					begin
						tx_nxt = {tx_r[6:0], 1'b0};
						oe_nxt = ~tx_r[6];
					end
				end
				ST_ADDR_ACK, ST_RDATA_ACK:
				begin
					done_nxt = 1'b0;
					bit_nxt  = 3'h0;
					if (st_r == ST_ADDR_ACK && !rw_r)
					begin
						st_nxt = ST_PTR;
						oe_nxt = 1'b0;
					end
					else if (st_r == ST_RDATA_ACK && nack_r)
					begin
						st_nxt = ST_IDLE;
						oe_nxt = 1'b0;
					end
					else
					begin
						st_nxt = ST_RDATA;
						tx_nxt = rd_mux;
						oe_nxt = ~rd_mux[7];
						rd_nxt = 1'b1;
					end
				end
				default: st_nxt = st_r;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			st_r    <= ST_IDLE;
			shift_r <= 8'h00;
			tx_r    <= 8'h00;
			ptr_r   <= 8'h00;
			bit_r   <= 3'h0;
			done_r  <= 1'b0;
			oe_r    <= 1'b0;
			rw_r    <= 1'b0;
			nack_r  <= 1'b0;
			rd_r    <= 1'b0;
			wr_r    <= 1'b0;
			wdat_r  <= 8'h00;
		end
		else
		begin
			st_r    <= st_nxt;
			shift_r <= shift_nxt;
			tx_r    <= tx_nxt;
			bit_r   <= bit_nxt;
			done_r  <= done_nxt;
			oe_r    <= oe_nxt;
			rw_r    <= rw_nxt;
			nack_r  <= nack_nxt;
			rd_r    <= rd_nxt;
			wr_r    <= wr_nxt;
			wdat_r  <= wr_nxt ? shift_r : wdat_r;
			// read pointer advances one cycle after the strobe so side effects see it
			ptr_r   <= rd_r ? ptr_r + 8'h01 : ptr_nxt;
		end
	end

	// ****************************************
	// operating mode and auto sleep
	// ****************************************
	logic [31:0] tick_r, tick_nxt;
	logic [7:0]  idle_r, idle_nxt;
	logic        mode_evt;

	always_comb
	begin
		mode_nxt = mode_r;
		tick_nxt = tick_r;
		idle_nxt = idle_r;
		mode_evt = 1'b0;
		case (mode_r)
			MODE_STANDBY:
			begin
				tick_nxt = 32'h0;
				idle_nxt = 8'h00;
				if (active_in)
					mode_nxt = MODE_WAKE;
			end
			MODE_WAKE:
			begin
				if (!active_in)
					mode_nxt = MODE_STANDBY;
				else if (det.any_irq || !auto_sleep_en)
				begin
					tick_nxt = 32'h0;
					idle_nxt = 8'h00;
				end
				else if (tick_r == TICK_CYCLES - 1)
				begin
					tick_nxt = 32'h0;
					if (idle_r >= sleep_countdown_limit)
					begin
						mode_nxt = MODE_SLEEP;
						mode_evt = 1'b1;
					end
					else
						idle_nxt = idle_r + 8'h01;
				end
				else
					tick_nxt = tick_r + 32'h1;
			end
			MODE_SLEEP:
			begin
				tick_nxt = 32'h0;
				idle_nxt = 8'h00;
				if (!active_in)
					mode_nxt = MODE_STANDBY;
				else if (det.wake_event || !auto_sleep_en)
				begin
					mode_nxt = MODE_WAKE;
					mode_evt = det.wake_event;
				end
			end
			default: mode_nxt = MODE_STANDBY;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			mode_r <= MODE_STANDBY;
			tick_r <= 32'h0;
			idle_r <= 8'h00;
			output_sample_rate <= 3'h0;
		end
		else
		begin
			mode_r <= mode_nxt;
			tick_r <= tick_nxt;
			idle_r <= idle_nxt;
			output_sample_rate <= (mode_r == MODE_SLEEP) ? low_rate : high_rate;
		end
	end

	// ****************************************
	// data flags, cause flags, configuration
	// ****************************************
	logic [2:0] pend_r, pend_nxt, seen_r, seen_nxt, msb_rd;
	logic       rdy_r, rdy_nxt, ow_r, ow_nxt, orch_r, orch_nxt, xyz_done;
	logic [5:0] src_r, src_now;
	logic [2:0] rate_off;
	logic       rd_at;

	assign rd_at  = rd_r;
	assign msb_rd = {rd_at && ptr_r == ADDR_Z_MSB, rd_at && ptr_r == ADDR_Y_MSB,
		rd_at && ptr_r == ADDR_X_MSB};
	// cleared only when every enabled axis high byte was read since the last clear
	assign xyz_done = ((seen_r | msb_rd) & det.axis_en) == det.axis_en;
	// bit order matches cause positions 7,5,4,3,2,0
	assign src_now = {mode_evt, det.trans_active & det.trans_en,
		orch_r & det.orient_en, det.pulse_active & det.pulse_en,
		det.ffmt_active & det.ffmt_en, (rdy_r | ow_r) & det.drdy_en};

	always_comb
	begin
		pend_nxt  = (pend_r & ~msb_rd) | (det.new_sample & det.axis_en);
		ow_nxt    = ow_r | (|(pend_r & ~msb_rd & det.new_sample & det.axis_en));
		rdy_nxt   = rdy_r | (|(det.new_sample & det.axis_en));
		seen_nxt  = seen_r | msb_rd;
		if (xyz_done && (rdy_r || ow_r))
		begin
			rdy_nxt  = |(det.new_sample & det.axis_en);
			// an overwrite landing in the clearing cycle still sets the flag
			ow_nxt   = |(pend_r & ~msb_rd & det.new_sample & det.axis_en);
			seen_nxt = 3'h0;
		end
		orch_nxt = det.orient_change | (orch_r & ~(rd_at && ptr_r == ADDR_ORIENT));
		cause_nxt = cause_r;
		// clears first, so a rise in the same cycle still sets the flag
		if (rd_at && ptr_r == ADDR_OP_STATE)
			cause_nxt[CAUSE_SLEEP_BIT] = 1'b0;
		if (rd_at && ptr_r == ADDR_TRANSIENT_SOURCE_REGISTER)
			cause_nxt[CAUSE_TRANS_BIT] = 1'b0;
		if (rd_at && ptr_r == ADDR_ORIENT)
			cause_nxt[CAUSE_ORIENT_BIT] = 1'b0;
		if (rd_at && ptr_r == ADDR_PULSE_SOURCE_REGISTER)
			cause_nxt[CAUSE_PULSE_BIT] = 1'b0;
		if (rd_at && ptr_r == ADDR_FFMT_SRC)
			cause_nxt[CAUSE_FFMT_BIT] = 1'b0;
		if (xyz_done && (rdy_r || ow_r))
			cause_nxt[CAUSE_DRDY_BIT] = 1'b0;
		cause_nxt[CAUSE_SLEEP_BIT]  = cause_nxt[CAUSE_SLEEP_BIT] | src_now[5];
		cause_nxt[CAUSE_TRANS_BIT]  = cause_nxt[CAUSE_TRANS_BIT] | (src_now[4] & ~src_r[4]);
		cause_nxt[CAUSE_ORIENT_BIT] = cause_nxt[CAUSE_ORIENT_BIT] | (src_now[3] & ~src_r[3]);
		cause_nxt[CAUSE_PULSE_BIT]  = cause_nxt[CAUSE_PULSE_BIT] | (src_now[2] & ~src_r[2]);
		cause_nxt[CAUSE_FFMT_BIT]   = cause_nxt[CAUSE_FFMT_BIT] | (src_now[1] & ~src_r[1]);
		cause_nxt[CAUSE_DRDY_BIT]   = cause_nxt[CAUSE_DRDY_BIT] | (src_now[0] & ~src_r[0]);
		cause_nxt[6] = 1'b0;
		cause_nxt[1] = 1'b0;
		range_nxt = range_r;
		hpf_nxt   = hpf_r;
		// reserved range code is refused and the old range kept
		if (wr_r && ptr_r == ADDR_RANGE && (wdat_r[1:0] != FS_RESERVED))
			range_nxt = wdat_r & RANGE_MASK;
		if (wr_r && ptr_r == ADDR_HPF)
			hpf_nxt = wdat_r & HPF_MASK;
		case (output_sample_rate)
			3'h0, 3'h1: rate_off = 3'h0;
			3'h2:       rate_off = 3'h1;
			3'h3:       rate_off = 3'h2;
			default:    rate_off = 3'h3;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			pend_r  <= 3'h0;
			seen_r  <= 3'h0;
			rdy_r   <= 1'b0;
			ow_r    <= 1'b0;
			orch_r  <= 1'b0;
			src_r   <= 6'h00;
			cause_r <= 8'h00;
			range_r <= RANGE_RESET;
			hpf_r   <= HPF_RESET;
			hp_cutoff_shift <= 3'h0;
		end
		else
		begin
			pend_r  <= pend_nxt;
			seen_r  <= seen_nxt;
			rdy_r   <= rdy_nxt;
			ow_r    <= ow_nxt;
			orch_r  <= orch_nxt;
			src_r   <= src_now;
			cause_r <= cause_nxt;
			range_r <= range_nxt;
			hpf_r   <= hpf_nxt;
			hp_cutoff_shift <= {1'b0, hpf_r[1:0]} + rate_off;
		end
	end

	assign sda_out                 = 1'b0;
	assign sda_oe                  = oe_r;
	assign reg_addr                = ptr_r;
	assign rd_strobe               = rd_r;
	assign wr_strobe               = wr_r;
	assign wr_data                 = wdat_r;
	assign operating_state_field   = mode_r;
	assign full_scale_select       = range_r[1:0];
	assign highpass_cutoff_config  = hpf_r;
	assign set_ready_flag          = rdy_r;
	assign set_overwrite_flag      = ow_r;
	assign orientation_change_flag = orch_r;

endmodule // accel_mode_irq_status_regs

// File: accel_regs_properties.sv
// assertions on the ports of the mode / interrupt-cause register group
`timescale 1ns/1ps

module accel_regs_properties
	import accel_regs_pkg::*;
#(
	parameter int TICK_CYCLES = SLEEP_TICK_CYCLES
)(
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire detect_in_t det,
	input wire logic       active_in,
	input wire logic       auto_sleep_en,
	input wire logic [2:0] high_rate,
	input wire logic [2:0] low_rate,
	input wire logic [7:0] reg_addr,
	input wire logic       rd_strobe,
	input wire logic [1:0] operating_state_field,
	input wire logic [2:0] output_sample_rate,
	input wire logic [1:0] full_scale_select,
	input wire logic [7:0] highpass_cutoff_config,
	input wire logic [2:0] hp_cutoff_shift,
	input wire logic       set_ready_flag,
	input wire logic       orientation_change_flag
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	AST_MODE_CODE: assert property (
		operating_state_field != 2'h3) else $error("unused operating state code");
	AST_STANDBY: assert property (
		!active_in |-> ##[1:3] operating_state_field == MODE_STANDBY) else $error("no standby");
	AST_RESET_CFG: assert property ($fell(reset) |-> full_scale_select == 2'h0
		&& highpass_cutoff_config == HPF_RESET) else $error("config not reset");
	AST_FS_CODE: assert property (
		full_scale_select != FS_RESERVED) else $error("reserved range code taken");
	AST_HPF_BITS: assert property (
		(highpass_cutoff_config & ~HPF_MASK) == 8'h00) else $error("unused cutoff bits set");
	AST_SLEEP_RATE: assert property (operating_state_field == MODE_SLEEP
		&& $past(operating_state_field) == MODE_SLEEP && $stable(low_rate)
		|-> output_sample_rate == low_rate) else $error("sleep rate wrong");
	AST_WAKE_RATE: assert property (operating_state_field == MODE_WAKE
		&& $past(operating_state_field) == MODE_WAKE && $stable(high_rate)
		|-> output_sample_rate == high_rate) else $error("wake rate wrong");
	AST_TO_SLEEP: assert property ($past(operating_state_field) == MODE_WAKE
		&& operating_state_field == MODE_SLEEP |-> $past(auto_sleep_en) && !$past(det.any_irq))
		else $error("sleep entered without countdown");
	AST_WAKE_UP: assert property (operating_state_field == MODE_SLEEP && det.wake_event
		&& auto_sleep_en && active_in |-> ##[1:3] operating_state_field == MODE_WAKE)
		else $error("wake event ignored");
	AST_READY_SET: assert property (
		det.new_sample[0] && det.axis_en[0] |-> ##[1:3] set_ready_flag) else $error("no ready");
	AST_ORIENT_CLR: assert property (rd_strobe && reg_addr == ADDR_ORIENT
		&& !det.orient_change && !$past(det.orient_change) |=> !orientation_change_flag)
		else $error("orientation change flag not cleared by read");
	AST_CUTOFF: assert property ($stable(highpass_cutoff_config)
		&& $stable(output_sample_rate) && highpass_cutoff_config[1:0] == 2'h0
		&& output_sample_rate == 3'h2 |-> hp_cutoff_shift == 3'h1) else $error("cutoff wrong");

endmodule // accel_regs_properties

bind accel_mode_irq_status_regs accel_regs_properties #(.TICK_CYCLES(TICK_CYCLES)) checks (
	.clk_sys(clk_sys), .reset(reset), .det(det), .active_in(active_in),
	.auto_sleep_en(auto_sleep_en), .high_rate(high_rate), .low_rate(low_rate),
	.reg_addr(reg_addr), .rd_strobe(rd_strobe), .operating_state_field(operating_state_field),
	.output_sample_rate(output_sample_rate), .full_scale_select(full_scale_select),
	.highpass_cutoff_config(highpass_cutoff_config), .hp_cutoff_shift(hp_cutoff_shift),
	.set_ready_flag(set_ready_flag), .orientation_change_flag(orientation_change_flag)
);

// File: i2c_host_model.sv
// host model: master on the serial register port
`timescale 1ns/1ps

module i2c_host_model
	import accel_regs_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_drv
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// data moves mid-low so it never lands beside an scl edge
	task automatic put_bit(input logic b);
		cyc(2);
		sda_drv <= b;
		cyc(2);
		scl <= 1'b1;
		cyc(4);
		scl <= 1'b0;
	endtask

	task automatic get_bit(output logic b);
		cyc(2);
		sda_drv <= 1'b1;
		cyc(2);
		scl <= 1'b1;
		cyc(4);
		b = sda_wire;
		scl <= 1'b0;
	endtask

	task automatic start();
		cyc(2);
		sda_drv <= 1'b1;
		cyc(2);
		scl <= 1'b1;
		cyc(4);
		sda_drv <= 1'b0;
		cyc(4);
		scl <= 1'b0;
	endtask

	task automatic stop();
		cyc(2);
		sda_drv <= 1'b0;
		cyc(2);
		scl <= 1'b1;
		cyc(4);
		sda_drv <= 1'b1;
		cyc(4);
	endtask

	task automatic send(input logic [7:0] b);
		logic a;
		for (int i = 7; i >= 0; i--)
			put_bit(b[i]);
		get_bit(a);
	endtask

	task automatic head(input logic [7:0] ptr);
		start();
		send({DEV_ADDR_DEF, 1'b0});
		send(ptr);
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$]);
		head(ptr);
		foreach (d[i])
			send(d[i]);
		stop();
	endtask

	task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] q [$]);
		logic [7:0] b;
		head(ptr);
		start();
		send({DEV_ADDR_DEF, 1'b1});
		q = {};
		for (int i = 0; i < n; i++)
		begin
			for (int j = 7; j >= 0; j--)
				get_bit(b[j]);
			put_bit(i == n - 1);
			q.push_back(b);
		end
		stop();
	endtask

endmodule // i2c_host_model

// File: accel_mode_irq_status_regs_tb.sv
// self-checking bench for the mode / interrupt-cause register group
`timescale 1ns/1ps

module accel_mode_irq_status_regs_tb
	import accel_regs_pkg::*;
();
	logic       clk_sys;
	logic       reset;
	detect_in_t det;
	logic       active_in;
	logic       auto_sleep_en;
	logic [7:0] sleep_countdown_limit;
	logic [2:0] high_rate;
	logic [2:0] low_rate;
	logic [7:0] ext_rd_data;
	logic       scl;
	logic       sda_drv;
	logic       sda_wire;
	logic       sda_out;
	logic       sda_oe;
	logic [7:0] reg_addr;
	logic       rd_strobe;
	logic       wr_strobe;
	logic [7:0] wr_data;
	logic [1:0] operating_state_field;
	logic [2:0] output_sample_rate;
	logic [1:0] full_scale_select;
	logic [7:0] highpass_cutoff_config;
	logic [2:0] hp_cutoff_shift;
	logic       set_ready_flag;
	logic       set_overwrite_flag;
	logic       orientation_change_flag;
	logic [7:0] q [$];
	int         mismatches;
	int         num_checks;

	// open drain with pull-up: any party pulling low wins
	assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);
	assign ext_rd_data = reg_addr ^ 8'ha5;

	accel_mode_irq_status_regs #(.TICK_CYCLES(4)) DUT (
		.clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe(sda_oe), .det(det), .active_in(active_in),
		.auto_sleep_en(auto_sleep_en), .sleep_countdown_limit(sleep_countdown_limit),
		.high_rate(high_rate), .low_rate(low_rate), .ext_rd_data(ext_rd_data),
		.reg_addr(reg_addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data),
		.operating_state_field(operating_state_field), .output_sample_rate(output_sample_rate),
		.full_scale_select(full_scale_select), .highpass_cutoff_config(highpass_cutoff_config),
		.hp_cutoff_shift(hp_cutoff_shift), .set_ready_flag(set_ready_flag),
		.set_overwrite_flag(set_overwrite_flag), .orientation_change_flag(orientation_change_flag)
	);

	i2c_host_model host (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, 1, q);
		check(q[0], e);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic t_reset();
		check({6'h00, operating_state_field}, 8'h00);
		host.rd(ADDR_OP_STATE, 5, q);
		check(q[0], 8'h00);
		check(q[1], 8'h00);
		check(q[2], IDENT_DEF);
		check(q[3], RANGE_RESET);
		check(q[4], HPF_RESET);
	endtask

	task automatic t_config();
		logic [1:0] fs;
		fs = 2'h0;
		for (int i = 0; i < 4; i++)
		begin
			host.wr(ADDR_RANGE, '{8'hfc | 8'(i)});
			// the reserved code must leave the last range standing
			if (i < 3)
				fs = 2'(i);
			expect_reg(ADDR_RANGE, {6'h00, fs});
			check({6'h00, full_scale_select}, {6'h00, fs});
		end
		host.wr(ADDR_OP_STATE, '{8'hff, 8'hff, 8'h00, 8'hff, 8'hff});
		check(wr_data, 8'hff);
		host.rd(ADDR_OP_STATE, 5, q);
		check(q[0], 8'h00);
		check(q[1], 8'h00);
		check(q[2], IDENT_DEF);
		check(q[3], 8'h02);
		check(q[4], HPF_MASK);
	endtask

	task automatic t_cutoff();
		int base [8] = '{0, 0, 1, 2, 3, 3, 3, 3};
		for (int s = 0; s < 4; s += 3)
		begin
			host.wr(ADDR_HPF, '{8'(s)});
			for (int r = 0; r < 8; r++)
			begin
				high_rate <= 3'(r);
				cyc(4);
				check({5'h00, hp_cutoff_shift}, 8'(s + base[r]));
			end
		end
	endtask

	task automatic set_src(input int k, input logic en, input logic act);
		det.trans_en <= (k == 0) & en;
		det.trans_active <= (k == 0) & act;
		det.pulse_en <= (k == 1) & en;
		det.pulse_active <= (k == 1) & act;
		det.ffmt_en <= (k == 2) & en;
		det.ffmt_active <= (k == 2) & act;
	endtask

	task automatic t_causes();
		logic [7:0] src [3] = '{ADDR_TRANSIENT_SOURCE_REGISTER, ADDR_PULSE_SOURCE_REGISTER, ADDR_FFMT_SRC};
		logic [7:0] bits [3] = '{8'h20, 8'h08, 8'h04};
		for (int k = 0; k < 3; k++)
		begin
			set_src(k, 1'b0, 1'b1);
			cyc(4);
			set_src(k, 1'b1, 1'b0);
			expect_reg(ADDR_CAUSE, 8'h00);
			set_src(k, 1'b1, 1'b1);
			cyc(4);
			set_src(k, 1'b1, 1'b0);
			expect_reg(ADDR_CAUSE, bits[k]);
			expect_reg(ADDR_CAUSE, bits[k]);
			host.rd(src[k], 1, q);
			expect_reg(ADDR_CAUSE, 8'h00);
		end
		det.orient_en <= 1'b1;
		det.orient_change <= 1'b1;
		cyc(1);
		det.orient_change <= 1'b0;
		cyc(4);
		check({7'h00, orientation_change_flag}, 8'h01);
		expect_reg(ADDR_CAUSE, 8'h10);
		host.rd(ADDR_ORIENT, 1, q);
		check({7'h00, orientation_change_flag}, 8'h00);
		expect_reg(ADDR_CAUSE, 8'h00);
	endtask

	task automatic samples();
		det.new_sample <= 3'h7;
		cyc(1);
		det.new_sample <= 3'h0;
		cyc(4);
	endtask

	task automatic t_data();
		det.axis_en <= 3'h7;
		det.drdy_en <= 1'b1;
		samples();
		check({6'h00, set_overwrite_flag, set_ready_flag}, 8'h01);
		samples();
		check({6'h00, set_overwrite_flag, set_ready_flag}, 8'h03);
		expect_reg(ADDR_CAUSE, 8'h01);
		host.rd(ADDR_STATUS, 1, q);
		host.rd(ADDR_X_MSB, 1, q);
		host.rd(ADDR_Y_MSB, 1, q);
		expect_reg(ADDR_CAUSE, 8'h01);
		host.rd(ADDR_Z_MSB, 1, q);
		check({6'h00, set_overwrite_flag, set_ready_flag}, 8'h00);
		expect_reg(ADDR_CAUSE, 8'h00);
	endtask

	task automatic t_mode();
		int n;
		high_rate <= 3'h1;
		active_in <= 1'b1;
		auto_sleep_en <= 1'b1;
		// countdown is (limit + 1) * 4 = 1024 cycles; each pulse must restart it
		repeat (4)
		begin
			cyc(1000);
			check({6'h00, operating_state_field}, {6'h00, MODE_WAKE});
			det.any_irq <= 1'b1;
			cyc(1);
			det.any_irq <= 1'b0;
		end
		for (n = 0; n < 1100 && operating_state_field !== MODE_SLEEP; n++)
			cyc(1);
		cyc(2);
		check({6'h00, operating_state_field}, {6'h00, MODE_SLEEP});
		check({5'h00, output_sample_rate}, {5'h00, low_rate});
		expect_reg(ADDR_CAUSE, 8'h80);
		expect_reg(ADDR_OP_STATE, {6'h00, MODE_SLEEP});
		expect_reg(ADDR_CAUSE, 8'h00);
		det.wake_event <= 1'b1;
		cyc(1);
		det.wake_event <= 1'b0;
		cyc(4);
		check({6'h00, operating_state_field}, {6'h00, MODE_WAKE});
		check({5'h00, output_sample_rate}, 8'h01);
		expect_reg(ADDR_CAUSE, 8'h80);
		active_in <= 1'b0;
		auto_sleep_en <= 1'b0;
		cyc(4);
		check({6'h00, operating_state_field}, {6'h00, MODE_STANDBY});
	endtask

	initial
	begin
		reset = 1'b1;
		det = '0;
		active_in = 1'b0;
		auto_sleep_en = 1'b0;
		sleep_countdown_limit = 8'hff;
		high_rate = 3'h0;
		low_rate = 3'h6;
		mismatches = 0;
		num_checks = 0;
		cyc(20);
		reset <= 1'b0;
		cyc(4);
		t_reset();
		t_config();
		t_cutoff();
		t_causes();
		t_data();
		t_mode();
		results();
	end

	initial
	begin
		#2000000;
		mismatches++;
		results();
	end

endmodule // accel_mode_irq_status_regs_tb
